// ==== fcs_host_mem_model.sv ====
// host memory seen through the dma port, with wait states and a fault address
// assumes the sequencer holds req, addr and wdata until dmaAck
`timescale 1ns/1ps
`default_nettype none
module fcs_host_mem_model (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire fcs_pkg::fcs_dma_t dmaOut,
  input  wire logic [3:0]        ackDelay,
  input  wire logic [17:0]       errAddr,
  output fcs_pkg::fcs_word_t     dmaRdata,
  output logic                   dmaAck,
  output logic                   dmaErr,
  output logic [17:0]            lastAddr
);
  fcs_pkg::fcs_word_t mem [0:511];
  logic [3:0]         waitCnt;

  // data lines invert while idle so a stale word never looks valid
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dmaAck   <= 1'b0;
      dmaErr   <= 1'b0;
      waitCnt  <= 4'h0;
      lastAddr <= 18'h00000;
      dmaRdata <= 16'hA5A5;
      for (int i = 0; i < 512; i++) begin
        mem[i] <= 16'h1000 + 16'(i);
      end
    end else if (dmaAck) begin
      dmaAck   <= 1'b0;
      dmaErr   <= 1'b0;
      dmaRdata <= ~dmaRdata;
    end else if (dmaOut.req && waitCnt < ackDelay) begin
      waitCnt  <= waitCnt + 4'h1;
      dmaRdata <= ~dmaRdata;
    end else if (dmaOut.req) begin
      waitCnt  <= 4'h0;
      dmaAck   <= 1'b1;
      dmaErr   <= (dmaOut.addr == errAddr);
      lastAddr <= dmaOut.addr;
      if (dmaOut.write) begin
        mem[dmaOut.addr[9:1]] <= dmaOut.wdata;
      end else begin
        dmaRdata <= mem[dmaOut.addr[9:1]];
      end
    end else begin
      dmaRdata <= ~dmaRdata;
    end
  end
endmodule
`default_nettype wire

// ==== fcs_pkg.sv ====
// constants, carriers and states of the floppy command sequencer
// assumes one 40 MHz clock shared by register port, dma port and drive
//
// Notes on behaviour
// [RQ1] dma address or parity fault sets bit 11
// [RQ2] oversized buffer transfer sets bit 10
// [RQ3] status bit 9 always reads zero
// [RQ4] bit 8 shows the selected drive
// [RQ5] bit 7 drive ready, refreshed by status/init
// [RQ6] bit 6 deleted mark read or written
// [RQ7] bit 5 format of last drive access
// [RQ8] format mismatch sets bit 4, error, done
// [RQ9] bit 3 reports power failure
// [RQ10] bit 2 set when initialization finishes
// [RQ11] bit 1 only for two-sided 8-inch media
// [RQ12] crc fault sets bit 0, error, done
// [RQ13] go accepted only while done; else discarded
// [RQ14] accepted command clears done
// [RQ15] errors end with done, error, status in data
// [RQ16] three-bit function code decode
// [RQ17] host sends word count, then address
// [RQ18] zero word count: done without error
// [RQ19] count over 128 or 64: done and error
// [RQ20] fill by dma, then zero rest
// [RQ21] empty buffer to host memory by dma
// [RQ22] buffer commands end with done, status readable
// [RQ23] parameter writes only while transfer request set
// [RQ24] density select picks double or single format
// [RQ25] interrupt as done rises when enabled
// [RQ26] dma address 18 bits with extension bits
// [RQ27] ascending word addresses, two bytes apart
package fcs_pkg;
  typedef logic [15:0] fcs_word_t;

  localparam logic [2:0] FN_FILL    = 3'h0;
  localparam logic [2:0] FN_EMPTY   = 3'h1;
  localparam logic [2:0] FN_WRSEC   = 3'h2;
  localparam logic [2:0] FN_RDSEC   = 3'h3;
  localparam logic [2:0] FN_DENSITY = 3'h4;
  localparam logic [2:0] FN_STATUS  = 3'h5;
  localparam logic [2:0] FN_WRDEL   = 3'h6;
  localparam logic [2:0] FN_ERRCODE = 3'h7;

  localparam int CSR_GO    = 0;
  localparam int CSR_FN    = 1;
  localparam int CSR_UNIT  = 4;
  localparam int CSR_DONE  = 5;
  localparam int CSR_IE    = 6;
  localparam int CSR_TREQ  = 7;
  localparam int CSR_DS    = 8;
  localparam int CSR_EMUID = 11;
  localparam int CSR_EA    = 12;
  localparam int CSR_INIT  = 14;
  localparam int CSR_ERR   = 15;

  localparam logic REG_CSR = 1'b0;
  localparam logic REG_DBR = 1'b1;

  localparam logic [7:0]  WC_MAX_DD   = 8'h80;
  localparam logic [7:0]  WC_MAX_SD   = 8'h40;
  localparam int          BUF_WORDS   = 128;
  localparam logic [17:0] DMA_STEP    = 18'h00002;
  localparam int          INIT_CYCLES = 16;

  typedef struct packed {
    logic [3:0] unused;
    logic       nxm;
    logic       wordOvf;
    logic       rsvd;
    logic       unitSel;
    logic       ready;
    logic       deleted;
    logic       mediaFmt;
    logic       fmtErr;
    logic       powerLoss;
    logic       initDone;
    logic       twoSided;
    logic       crc;
  } fcs_status_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [17:0] addr;
    fcs_word_t   wdata;
  } fcs_dma_t;

  typedef struct packed {
    logic driveReady;
    logic mediaDouble;
    logic twoSided;
    logic is8in;
    logic powerFail;
    logic crcFault;
    logic deletedMark;
  } fcs_disk_t;

  typedef enum logic [3:0] {
    ST_INIT, ST_IDLE, ST_PARAM, ST_EXEC, ST_FILL,
    ST_ZERO, ST_EMPTY_RD, ST_EMPTY_DMA, ST_FINISH
  } fcs_state_t;
endpackage

// ==== fcs_sector_buf.sv ====
// sector buffer: one write port, one registered read port
// assumes caller keeps addresses inside the buffer
`timescale 1ns/1ps
`default_nettype none
module fcs_sector_buf #(
  parameter int WORDS = fcs_pkg::BUF_WORDS,
  parameter int AW    = $clog2(fcs_pkg::BUF_WORDS)
) (
  input  wire logic              clk,
  input  wire logic              wrEn,
  input  wire logic [AW-1:0]     wrAddr,
  input  wire fcs_pkg::fcs_word_t wrData,
  input  wire logic              rdEn,
  input  wire logic [AW-1:0]     rdAddr,
  output fcs_pkg::fcs_word_t     rdData
);
  fcs_pkg::fcs_word_t mem [WORDS];

  if (WORDS < 2 || WORDS > (1 << AW)) begin : gBadSize
    $error("buffer size does not fit its address width");
  end

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

// ==== fcs_sequencer.sv ====
// command sequencer: csr/data register port, dma master, sector buffer
// assumes host follows the data register handshake, dma answers with ack
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer #(
  parameter int BUF_WORDS   = fcs_pkg::BUF_WORDS,
  parameter int INIT_CYCLES = fcs_pkg::INIT_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               regSel,
  input  wire logic               regWr,
  input  wire logic               regRd,
  input  wire fcs_pkg::fcs_word_t regWdata,
  output fcs_pkg::fcs_word_t      regRdata,
  output logic                    hostIrq,
  output fcs_pkg::fcs_dma_t       dmaOut,
  input  wire fcs_pkg::fcs_word_t dmaRdata,
  input  wire logic               dmaAck,
  input  wire logic               dmaErr,
  input  wire fcs_pkg::fcs_disk_t diskIn
);
  localparam int AW = $clog2(BUF_WORDS);
  localparam logic [AW-1:0] LAST_IDX = AW'(BUF_WORDS - 1);

  if (BUF_WORDS < 128 || BUF_WORDS != (1 << AW)) begin : gBadBuf
    $error("BUF_WORDS must be a power of two, at least 128");
  end
  if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : gBadInit
    $error("INIT_CYCLES must lie in 1..65535");
  end

  function automatic logic [1:0] paramCount(input logic [2:0] fn);
    case (fn)
      fcs_pkg::FN_STATUS:  paramCount = 2'h0;
      fcs_pkg::FN_DENSITY: paramCount = 2'h1;
      fcs_pkg::FN_ERRCODE: paramCount = 2'h1;
      default:             paramCount = 2'h2;
    endcase
  endfunction

  function automatic logic isSector(input logic [2:0] fn);
    isSector = fn == fcs_pkg::FN_WRSEC || fn == fcs_pkg::FN_RDSEC ||
               fn == fcs_pkg::FN_WRDEL;
  endfunction

  fcs_pkg::fcs_state_t  state;
  fcs_pkg::fcs_status_t statReg;
  fcs_pkg::fcs_word_t   dbrReg;
  fcs_pkg::fcs_word_t   param1Reg, param2Reg;
  fcs_pkg::fcs_word_t   bufRdata;
  fcs_pkg::fcs_word_t   csrView;
  logic [2:0]           fnReg;
  logic                 unitReg, ieReg, dsReg;
  logic [1:0]           eaReg;
  logic                 doneReg, errReg, doneQ, ieQ;
  logic                 paramIdx;
  logic [17:0]          addrReg;
  logic [7:0]           cntReg;
  logic [AW-1:0]        idxReg;
  logic [15:0]          initCnt;
  logic                 csrWr, dbrWr, softInit, accept, inExec, cmdIsBuf;
  logic [7:0]           wc, wcLimit;
  logic                 mismatch, fmtChecked, dmaStep, bufWr, lastParam;
  logic                 ovfFault, fmtFault, crcFault, nxmFault;

  assign csrWr    = regWr && regSel == fcs_pkg::REG_CSR;
  assign dbrWr    = regWr && regSel == fcs_pkg::REG_DBR;
  assign softInit = csrWr && regWdata[fcs_pkg::CSR_INIT];
  // commands written while busy fall through here unseen; see RQ13
  assign accept   = csrWr && regWdata[fcs_pkg::CSR_GO] && doneReg &&
                    !softInit && state == fcs_pkg::ST_IDLE;
  assign inExec   = state == fcs_pkg::ST_EXEC;
  assign cmdIsBuf = fnReg == fcs_pkg::FN_FILL || fnReg == fcs_pkg::FN_EMPTY;
  assign wc       = param1Reg[7:0];
  // density select picks the per-command transfer limit; see RQ24
  assign wcLimit  = dsReg ? fcs_pkg::WC_MAX_DD : fcs_pkg::WC_MAX_SD;
  assign mismatch = dsReg != diskIn.mediaDouble;
  assign fmtChecked = isSector(fnReg) ||
                      (fnReg == fcs_pkg::FN_STATUS && diskIn.driveReady);
  assign ovfFault = inExec && cmdIsBuf && wc > wcLimit; // see RQ19
  assign fmtFault = inExec && !cmdIsBuf && fmtChecked && mismatch;
  assign crcFault = inExec && fnReg == fcs_pkg::FN_RDSEC && !mismatch &&
                    diskIn.crcFault;
  assign dmaStep  = dmaAck && (state == fcs_pkg::ST_FILL ||
                               state == fcs_pkg::ST_EMPTY_DMA);
  assign nxmFault = dmaStep && dmaErr;
  assign bufWr    = (state == fcs_pkg::ST_FILL && dmaAck && !dmaErr) ||
                    state == fcs_pkg::ST_ZERO;
  assign lastParam = paramCount(fnReg) == 2'h2 ? paramIdx : 1'b1;

  // sequencing of one command from acceptance to done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= fcs_pkg::ST_INIT;
    end else if (softInit) begin
      state <= fcs_pkg::ST_INIT; // see RQ10
    end else begin
      case (state)
        fcs_pkg::ST_INIT: begin
          if (initCnt == 16'h0000) state <= fcs_pkg::ST_FINISH;
        end
        fcs_pkg::ST_IDLE: begin
          if (accept) begin // see RQ16
            if (paramCount(regWdata[3:1]) == 2'h0) state <= fcs_pkg::ST_EXEC;
            else state <= fcs_pkg::ST_PARAM;
          end
        end
        fcs_pkg::ST_PARAM: begin
          if (dbrWr && lastParam) state <= fcs_pkg::ST_EXEC; // see RQ17
        end
        fcs_pkg::ST_EXEC: begin
          if (cmdIsBuf && wc != 8'h00 && !ovfFault) begin
            if (fnReg == fcs_pkg::FN_FILL) state <= fcs_pkg::ST_FILL;
            else state <= fcs_pkg::ST_EMPTY_RD;
          end else begin
            state <= fcs_pkg::ST_FINISH; // see RQ18
          end
        end
        fcs_pkg::ST_FILL: begin
          if (dmaAck) begin
            if (dmaErr) state <= fcs_pkg::ST_FINISH;
            else if (cntReg == 8'h01) begin
              if (idxReg == LAST_IDX) state <= fcs_pkg::ST_FINISH;
              else state <= fcs_pkg::ST_ZERO; // see RQ20
            end
          end
        end
        fcs_pkg::ST_ZERO: begin
          if (idxReg == LAST_IDX) state <= fcs_pkg::ST_FINISH;
        end
        fcs_pkg::ST_EMPTY_RD: begin
          state <= fcs_pkg::ST_EMPTY_DMA;
        end
        fcs_pkg::ST_EMPTY_DMA: begin
          if (dmaAck) begin
            if (dmaErr || cntReg == 8'h01) state <= fcs_pkg::ST_FINISH;
            else state <= fcs_pkg::ST_EMPTY_RD; // see RQ21
          end
        end
        fcs_pkg::ST_FINISH: begin
          state <= fcs_pkg::ST_IDLE;
        end
        default: begin
          state <= fcs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // initialization delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initCnt <= 16'(INIT_CYCLES);
    end else if (softInit) begin
      initCnt <= 16'(INIT_CYCLES);
    end else if (state == fcs_pkg::ST_INIT && initCnt != 16'h0000) begin
      initCnt <= initCnt - 16'h0001;
    end
  end

  // command fields latched from the csr
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fnReg   <= 3'h0;
      unitReg <= 1'b0;
      dsReg   <= 1'b0;
      eaReg   <= 2'h0;
      ieReg   <= 1'b0;
    end else if (softInit) begin
      ieReg <= 1'b0;
    end else if (csrWr) begin
      ieReg <= regWdata[fcs_pkg::CSR_IE];
      if (accept) begin
        fnReg   <= regWdata[3:1];
        unitReg <= regWdata[fcs_pkg::CSR_UNIT];
        dsReg   <= regWdata[fcs_pkg::CSR_DS];
        eaReg   <= regWdata[13:12];
      end
    end
  end

  // done and error flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doneReg <= 1'b0;
      errReg  <= 1'b0;
    end else if (softInit || accept) begin
      doneReg <= 1'b0; // see RQ14
      errReg  <= 1'b0;
    end else begin
      if (state == fcs_pkg::ST_FINISH) doneReg <= 1'b1; // see RQ22
      if (ovfFault || fmtFault || crcFault || nxmFault) begin
        errReg <= 1'b1; // see RQ15
      end
    end
  end

  // parameter capture and dma walk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      paramIdx  <= 1'b0;
      param1Reg <= 16'h0000;
      param2Reg <= 16'h0000;
      addrReg   <= 18'h00000;
      cntReg    <= 8'h00;
      idxReg    <= '0;
    end else if (accept) begin
      paramIdx <= 1'b0;
    end else if (state == fcs_pkg::ST_PARAM && dbrWr) begin
      paramIdx <= 1'b1; // see RQ23
      if (paramIdx) param2Reg <= regWdata;
      else param1Reg <= regWdata;
    end else if (inExec) begin
      addrReg <= {eaReg, param2Reg}; // see RQ26
      cntReg  <= wc;
      idxReg  <= '0;
    end else if (dmaStep && !dmaErr) begin
      addrReg <= addrReg + fcs_pkg::DMA_STEP; // see RQ27
      cntReg  <= cntReg - 8'h01;
      idxReg  <= idxReg + 1'b1;
    end else if (state == fcs_pkg::ST_ZERO) begin
      idxReg <= idxReg + 1'b1;
    end
  end

  // error and status word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statReg <= '0;
    end else begin
      statReg.powerLoss <= diskIn.powerFail; // see RQ9
      statReg.unitSel   <= unitReg;          // see RQ4
      if (softInit) begin
        statReg.initDone <= 1'b0;
      end else if (state == fcs_pkg::ST_INIT && initCnt == 16'h0000) begin
        statReg.initDone <= 1'b1;              // see RQ10
        statReg.ready    <= diskIn.driveReady; // see RQ5
      end
      if (accept) begin
        statReg.nxm     <= 1'b0;
        statReg.wordOvf <= 1'b0;
        statReg.fmtErr  <= 1'b0;
        statReg.crc     <= 1'b0;
        statReg.deleted <= 1'b0;
      end
      if (ovfFault) statReg.wordOvf <= 1'b1; // see RQ2
      if (fmtFault) statReg.fmtErr <= 1'b1;  // see RQ8
      if (crcFault) statReg.crc <= 1'b1;     // see RQ12
      if (nxmFault) statReg.nxm <= 1'b1;     // see RQ1
      if (inExec && fnReg == fcs_pkg::FN_STATUS) begin
        statReg.ready <= diskIn.driveReady; // see RQ5
      end
      if (inExec && fmtChecked) begin
        statReg.mediaFmt <= diskIn.mediaDouble; // see RQ7
        statReg.twoSided <= diskIn.twoSided && diskIn.is8in; // see RQ11
      end
      if (inExec && !mismatch) begin
        if (fnReg == fcs_pkg::FN_WRDEL) statReg.deleted <= 1'b1; // see RQ6
        if (fnReg == fcs_pkg::FN_RDSEC) begin
          statReg.deleted <= diskIn.deletedMark;
        end
      end
    end
  end

  // data register: host parameters, then the status word at the end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dbrReg <= 16'h0000;
    end else if (state == fcs_pkg::ST_FINISH) begin
      dbrReg <= {4'h0, statReg[11:10], 1'b0, statReg[8:0]}; // see RQ3
    end else if (state == fcs_pkg::ST_PARAM && dbrWr) begin
      dbrReg <= regWdata;
    end
  end

  always_comb begin
    csrView = 16'h0000;
    csrView[fcs_pkg::CSR_ERR]   = errReg;
    csrView[fcs_pkg::CSR_EMUID] = 1'b1;
    csrView[fcs_pkg::CSR_DS]    = dsReg && doneReg;
    csrView[fcs_pkg::CSR_TREQ]  = state == fcs_pkg::ST_PARAM;
    csrView[fcs_pkg::CSR_IE]    = ieReg;
    csrView[fcs_pkg::CSR_DONE]  = doneReg;
    csrView[fcs_pkg::CSR_UNIT]  = unitReg && doneReg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      regRdata <= regSel == fcs_pkg::REG_DBR ? dbrReg : csrView;
    end
  end

  // one pulse when done rises with enable set, or enable rises while done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doneQ   <= 1'b0;
      ieQ     <= 1'b0;
      hostIrq <= 1'b0;
    end else begin
      doneQ   <= doneReg;
      ieQ     <= ieReg;
      hostIrq <= ieReg && doneReg && !(ieQ && doneQ); // see RQ25
    end
  end

  always_comb begin
    dmaOut.req   = state == fcs_pkg::ST_FILL ||
                   state == fcs_pkg::ST_EMPTY_DMA;
    dmaOut.write = state == fcs_pkg::ST_EMPTY_DMA;
    dmaOut.addr  = addrReg;
    dmaOut.wdata = bufRdata;
  end

  fcs_sector_buf #(
    .WORDS (BUF_WORDS),
    .AW    (AW)
  ) uBuf (
    .clk    (clk),
    .wrEn   (bufWr),
    .wrAddr (idxReg),
    .wrData (state == fcs_pkg::ST_ZERO ? 16'h0000 : dmaRdata),
    .rdEn   (state == fcs_pkg::ST_EMPTY_RD),
    .rdAddr (idxReg),
    .rdData (bufRdata)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rsvd_bit_zero_a: assert property ( // see RQ3
    state == fcs_pkg::ST_FINISH |=> !dbrReg[9])
    else $error("reserved status bit not zero");
  busy_discard_a: assert property ( // see RQ13
    csrWr && !doneReg && !softInit |=> $stable(fnReg) && $stable(eaReg) &&
      (!doneReg || $past(state == fcs_pkg::ST_FINISH)))
    else $error("command taken while busy");
  accept_done_a: assert property ( // see RQ14
    accept |=> !doneReg && !errReg)
    else $error("done not cleared on accept");
  zero_count_a: assert property ( // see RQ18
    inExec && cmdIsBuf && wc == 8'h00 |=> ##1 doneReg && !errReg)
    else $error("zero count ended wrongly");
  count_ovf_a: assert property ( // see RQ19
    ovfFault |=> ##1 doneReg && errReg && dbrReg[10])
    else $error("overflow not reported");
  dma_nxm_a: assert property ( // see RQ1
    nxmFault |=> ##1 doneReg && errReg && dbrReg[11])
    else $error("dma fault not reported");
  fmt_err_a: assert property ( // see RQ8
    fmtFault |=> ##1 doneReg && errReg && dbrReg[4])
    else $error("format mismatch not reported");
  zero_fill_a: assert property ( // see RQ20
    state == fcs_pkg::ST_ZERO |-> bufWr && idxReg == $past(idxReg) + 1'b1)
    else $error("zero fill out of order");
  dma_step_a: assert property ( // see RQ27
    dmaStep && !dmaErr && cntReg != 8'h01 |=>
      dmaOut.addr == $past(addrReg) + fcs_pkg::DMA_STEP)
    else $error("dma address did not step by two");
  irq_pulse_a: assert property ( // see RQ25
    $rose(doneReg) && ieReg && $past(ieReg) |=> hostIrq ##1 !hostIrq)
    else $error("interrupt not raised on done");
endmodule
`default_nettype wire

// ==== floppy_command_sequencer_tb_top.sv ====
// self-checking bench: register port tasks, host memory model on dma port
// assumes the sequencer with a short init count and one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module floppy_command_sequencer_tb_top;
  logic               clk;
  logic               rst;
  logic               regSel;
  logic               regWr;
  logic               regRd;
  fcs_pkg::fcs_word_t regWdata;
  fcs_pkg::fcs_word_t regRdata;
  logic               hostIrq;
  fcs_pkg::fcs_dma_t  dmaOut;
  fcs_pkg::fcs_word_t dmaRdata;
  logic               dmaAck;
  logic               dmaErr;
  fcs_pkg::fcs_disk_t diskIn;
  logic [3:0]         ackDelay;
  logic [17:0]        errAddr;
  logic [17:0]        lastAddr;
  fcs_pkg::fcs_word_t c;
  fcs_pkg::fcs_word_t s;
  int                 err_total;
  int                 cmp_count;
  int                 irqCount;
  int                 cycles;
  int                 i0;

  fcs_sequencer #(.INIT_CYCLES(2)) i_fcs_sequencer (
    .clk(clk), .rst(rst), .regSel(regSel), .regWr(regWr), .regRd(regRd),
    .regWdata(regWdata), .regRdata(regRdata), .hostIrq(hostIrq),
    .dmaOut(dmaOut), .dmaRdata(dmaRdata), .dmaAck(dmaAck), .dmaErr(dmaErr),
    .diskIn(diskIn)
  );
  fcs_host_mem_model i_fcs_host_mem_model (
    .clk(clk), .rst(rst), .dmaOut(dmaOut), .ackDelay(ackDelay),
    .errAddr(errAddr), .dmaRdata(dmaRdata), .dmaAck(dmaAck),
    .dmaErr(dmaErr), .lastAddr(lastAddr)
  );

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (hostIrq === 1'b1) irqCount++;
    if (cycles == 60000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic sel, input fcs_pkg::fcs_word_t d);
    @(posedge clk);
    #2;
    regSel = sel;
    regWdata = d;
    regWr = 1'b1;
    @(posedge clk);
    #2;
    regWr = 1'b0;
  endtask

  task automatic reg_rd(input logic sel, output fcs_pkg::fcs_word_t d);
    @(posedge clk);
    #2;
    regSel = sel;
    regRd = 1'b1;
    @(posedge clk);
    #2;
    regRd = 1'b0;
    d = regRdata;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      reg_rd(fcs_pkg::REG_CSR, c);
      n++;
    end while (c[fcs_pkg::CSR_DONE] !== 1'b1 && n < 3000);
    if (n >= 3000) check(18'h1, 18'h0);
    reg_rd(fcs_pkg::REG_DBR, s);
  endtask

  // csr image: ext address 01, go set; parameters wait for xfer_request
  task automatic issue(input logic [2:0] fn, input logic ds, input logic un,
                       input logic ie, input int np,
                       input fcs_pkg::fcs_word_t p0, input fcs_pkg::fcs_word_t p1);
    fcs_pkg::fcs_word_t t;
    int n;
    reg_wr(fcs_pkg::REG_CSR, {4'h1, 3'h0, ds, 1'b0, ie, 1'b0, un, fn, 1'b1});
    for (int k = 0; k < np; k++) begin
      n = 0;
      do begin
        reg_rd(fcs_pkg::REG_CSR, t);
        n++;
      end while (t[fcs_pkg::CSR_TREQ] !== 1'b1 && n < 100);
      if (t[fcs_pkg::CSR_TREQ] !== 1'b1) check(18'h1, 18'h0);
      reg_wr(fcs_pkg::REG_DBR, (k == 0) ? p0 : p1);
    end
  endtask

  initial begin
    int wcs [4] = '{0, 64, 65, 129};
    logic dss [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic ers [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    int nps [8] = '{2, 2, 2, 2, 1, 0, 2, 1};
    err_total = 0;
    cmp_count = 0;
    irqCount = 0;
    cycles = 0;
    rst = 1'b1;
    regSel = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regWdata = 16'h0000;
    ackDelay = 4'h0;
    errAddr = 18'h3FFFE;
    diskIn = 7'h70;
    repeat (5) @(posedge clk);
    #2;
    rst = 1'b0;
    wait_done();
    check({2'h0, s & 16'h020E}, 18'h00004);
    // not ready, power loss, unit 1
    diskIn = 7'h24;
    issue(fcs_pkg::FN_STATUS, 1'b1, 1'b1, 1'b0, 0, 16'h0000, 16'h0000);
    wait_done();
    check({2'h0, s & 16'h0188}, 18'h00108);
    diskIn = 7'h60;
    i0 = irqCount;
    issue(fcs_pkg::FN_FILL, 1'b1, 1'b0, 1'b1, 2, 16'h0003, 16'h0100);
    wait_done();
    check(18'(irqCount - i0), 18'h1);
    check({2'h0, c[15], 3'h0, s[11:0]} & 18'h08C00, 18'h0);
    issue(fcs_pkg::FN_EMPTY, 1'b1, 1'b0, 1'b0, 2, 16'h0005, 16'h0200);
    wait_done();
    for (int k = 0; k < 5; k++) begin
      check({2'h0, i_fcs_host_mem_model.mem[256 + k]},
            (k < 3) ? 18'(16'h1080 + k) : 18'h0);
    end
    check(lastAddr, 18'h10208);
    for (int k = 0; k < 4; k++) begin
      issue(fcs_pkg::FN_FILL, dss[k], 1'b0, 1'b0, 2, 16'(wcs[k]), 16'h0100);
      wait_done();
      check({16'h0, c[15], s[10]}, {16'h0, ers[k], ers[k]});
    end
    ackDelay = 4'h6;
    issue(fcs_pkg::FN_EMPTY, 1'b1, 1'b0, 1'b0, 2, 16'h0002, 16'h0300);
    reg_rd(fcs_pkg::REG_CSR, c);
    check({17'h0, c[fcs_pkg::CSR_DONE]}, 18'h0);
    reg_wr(fcs_pkg::REG_CSR, 16'h1001);
    wait_done();
    check(lastAddr, 18'h10302);
    check({2'h0, i_fcs_host_mem_model.mem[385]}, 18'h01081);
    ackDelay = 4'h0;
    errAddr = 18'h10102;
    issue(fcs_pkg::FN_FILL, 1'b1, 1'b0, 1'b0, 2, 16'h0003, 16'h0100);
    wait_done();
    check({16'h0, c[15], s[11]}, 18'h3);
    errAddr = 18'h3FFFE;
    for (int f = 2; f < 8; f++) begin
      issue(3'(f), 1'b1, 1'b0, 1'b0, nps[f], 16'h0001, 16'h0000);
      wait_done();
      check({16'h0, c[15], s[6]}, {17'h0, f == 6});
    end
    issue(fcs_pkg::FN_WRSEC, 1'b0, 1'b0, 1'b0, 2, 16'h0001, 16'h0000);
    wait_done();
    check({16'h0, c[15], s[4]}, 18'h3);
    diskIn.crcFault = 1'b1;
    issue(fcs_pkg::FN_RDSEC, 1'b1, 1'b0, 1'b0, 2, 16'h0001, 16'h0000);
    wait_done();
    check({16'h0, c[15], s[0]}, 18'h3);
    // soft restart clears the error and reruns initialization
    reg_wr(fcs_pkg::REG_CSR, 16'h4000);
    wait_done();
    check({16'h0, c[15], s[2]}, 18'h1);
    // ready, double density, two-sided 8-inch media
    diskIn = 7'h78;
    issue(fcs_pkg::FN_STATUS, 1'b1, 1'b0, 1'b0, 0, 16'h0000, 16'h0000);
    wait_done();
    check({15'h0, c[15], s[5], s[1]}, 18'h3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
